/* File: core/psec_event_merge.sv */
`timescale 1ns/1ps

`include "psec_map.svh"

module psec_event_merge
(
  input  wire logic                      sys_clk,   // Profiler clock
  input  wire logic                      sys_rst,   // Async reset, high
  input  wire logic [`PSEC_NUM_WS-1:0]   events,    // Wait-state events
  input  wire logic [`PSEC_NUM_WS-1:0]   mask,      // Combine enables
  output logic                           combined   // Registered event
);

  logic next_combined;

  // OR of enabled events
  always_comb
  begin
    next_combined = |(events & mask);
  end

  // Register event
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      combined <= 1'b0;
    else
      combined <= next_combined;
  end

endmodule : psec_event_merge

/* File: core/psec_sat_capture.sv */
`timescale 1ns/1ps

`include "psec_map.svh"

module psec_sat_capture
(
  input  wire logic                sys_clk,   // Profiler clock
  input  wire logic                sys_rst,   // Async reset, high
  input  wire psec_pkg::psec_sat_t sat_in,    // Counter saturation levels
  output logic [`PSEC_CNT_W-1:0]   status     // Status word
);

  logic [`PSEC_CNT_W-1:0] next_status;

  // Place saturation flags into status word
  always_comb
  begin
    next_status = '0;
    next_status[`PSEC_PREFETCH_BIT] = sat_in.prefetch_count_saturated;
    next_status[`PSEC_NUM_WS-1:0]   = sat_in.wait_state_count_saturated;
  end

  // Register status word
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      status <= '0;
    else
      status <= next_status;
  end

endmodule : psec_sat_capture

/* File: core/psec_top.sv */
`timescale 1ns/1ps

`include "psec_map.svh"

module psec_top
(
  input  wire logic                    sys_clk,            // 100 MHz clock
  input  wire logic                    sys_rst,            // Async reset, high
  input  wire logic [`PSEC_ADDR_W-1:0] avs_address,        // Byte address
  input  wire logic                    avs_read,           // Read request
  input  wire logic                    avs_write,          // Write request
  input  wire logic [31:0]             avs_writedata,      // Write data
  input  wire logic [3:0]              avs_byteenable,     // Byte lanes
  output logic [31:0]                  avs_readdata,       // Read data
  output logic                         avs_waitrequest,    // Stall
  input  wire logic                    prefetch_count_saturated, // Level
  input  wire logic [7:0]              wait_count_saturated,     // Levels
  input  wire logic [7:0]              wait_read_events,   // Pulses
  output logic                         core_trace_trigger_event  // To core
);

  // --------------------------------------------------------------------
  // Saturation status capture
  // --------------------------------------------------------------------
  psec_pkg::psec_sat_t     sat_bundle;
  logic [`PSEC_CNT_W-1:0]  sat_status;

  // Bundle counter saturation flags
  always_comb
  begin
    sat_bundle.prefetch_count_saturated   = prefetch_count_saturated;
    sat_bundle.wait_state_count_saturated = wait_count_saturated;
  end

  psec_sat_capture u_sat
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .sat_in  (sat_bundle),
    .status  (sat_status)
  );

  // --------------------------------------------------------------------
  // Mask register and bus slave state
  // --------------------------------------------------------------------
  logic [`PSEC_NUM_WS-1:0]    event_mask;
  logic [`PSEC_NUM_WS-1:0]    next_event_mask;
  psec_pkg::psec_bus_state_t  bus_state;
  psec_pkg::psec_bus_state_t  next_bus_state;
  logic [31:0]                next_readdata;
  logic                       next_waitrequest;

  // Address decode helper
  function automatic logic [31:0] read_word
  (
    input logic [`PSEC_ADDR_W-1:0] addr,
    input logic [`PSEC_CNT_W-1:0]  status,
    input logic [`PSEC_NUM_WS-1:0] mask
  );
    logic [31:0] word;
    word = `PSEC_UNMAPPED_DATA;
    case (addr)
      `PSEC_OFF_SAT_STATUS: word = status;
      `PSEC_OFF_EVT_MASK:   word = {24'h000000, mask};
      default:              word = `PSEC_UNMAPPED_DATA;
    endcase
    return word;
  endfunction : read_word

  // Next state of slave, mask and read data
  always_comb
  begin
    next_bus_state   = bus_state;
    next_event_mask  = event_mask;
    next_readdata    = avs_readdata;
    next_waitrequest = 1'b1;
    case (bus_state)
      psec_pkg::PSEC_IDLE:
      begin
        if (avs_write)
        begin
          if (avs_address == `PSEC_OFF_EVT_MASK && avs_byteenable[0])
            next_event_mask = avs_writedata[`PSEC_NUM_WS-1:0];
          // Status word and unmapped writes are dropped
          next_waitrequest = 1'b0;
          next_bus_state   = psec_pkg::PSEC_DONE;
        end
        else if (avs_read)
        begin
          next_readdata    = read_word(avs_address, sat_status,
                                       event_mask);
          next_waitrequest = 1'b0;
          next_bus_state   = psec_pkg::PSEC_DONE;
        end
      end
      psec_pkg::PSEC_DONE:
      begin
        next_bus_state = psec_pkg::PSEC_IDLE;
      end
      psec_pkg::PSEC_RDATA:
      begin
        next_bus_state = psec_pkg::PSEC_IDLE;
      end
      default:
      begin
        next_bus_state = psec_pkg::PSEC_IDLE;
      end
    endcase
  end

  // Register slave state
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_state       <= psec_pkg::PSEC_IDLE;
      event_mask      <= `PSEC_MASK_RESET;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      bus_state       <= next_bus_state;
      event_mask      <= next_event_mask;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
    end
  end

  // --------------------------------------------------------------------
  // Event combiner
  // --------------------------------------------------------------------
  psec_event_merge u_merge
  (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .events   (wait_read_events),
    .mask     (event_mask),
    .combined (core_trace_trigger_event)
  );

endmodule : psec_top

/* File: inc/psec_map.svh */
`ifndef PSEC_MAP_SVH
`define PSEC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, word aligned)
// ----------------------------------------------------------------------
`define PSEC_ADDR_W         8
`define PSEC_OFF_SAT_STATUS 8'h2c
`define PSEC_OFF_EVT_MASK   8'h30

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define PSEC_NUM_WS         8
`define PSEC_PREFETCH_BIT   8
`define PSEC_CNT_W          32
`define PSEC_MASK_RESET     8'h00
`define PSEC_UNMAPPED_DATA  32'h0000_0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PSEC_READ_LATENCY   1

`endif

/* File: inc/psec_pkg.sv */
package psec_pkg;

  // Counter saturation inputs grouped together
  typedef struct packed {
    logic       prefetch_count_saturated;
    logic [7:0] wait_state_count_saturated;
  } psec_sat_t;

  // Bus slave states
  typedef enum logic [2:0] {
    PSEC_IDLE  = 3'b001,
    PSEC_RDATA = 3'b010,
    PSEC_DONE  = 3'b100
  } psec_bus_state_t;

endpackage : psec_pkg

/* File: tb/profiler_saturation_event_combiner_tb.sv */
`timescale 1ns/1ps
module profiler_saturation_event_combiner_tb;
  logic        sys_clk = 0, sys_rst = 1, rd = 0, wr = 0, ps = 0, on = 0, tg;
  logic [7:0]  ad = 0, ws = 0, ev = 0, tm = 0;
  logic [31:0] wd = 0, rdat, seed = 32'hc8c99f70;
  logic [3:0]  be = 4'hf;
  logic        wt, xp = 0;
  logic [15:0] hits, xh = 0;
  int          fails = 0, check_count = 0, i;
  logic [31:0] q[$];
  psec_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(ad),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wt), .prefetch_count_saturated(ps),
    .wait_count_saturated(ws), .wait_read_events(ev),
    .core_trace_trigger_event(tg));
  psec_core_model core (.sys_clk(sys_clk), .sys_rst(sys_rst), .trig(tg),
    .hits(hits));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  // One bus transfer; a read queues its expected data
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    if (!w) q.push_back(d);
    rd <= !w; wr <= w; ad <= a; wd <= d; be <= b;
    // Hold the request until waitrequest is sampled low
    do @(posedge sys_clk); while (wt !== 1'b0);
    if (w && a == 8'h30 && b[0]) tm = d[7:0];
    rd <= 0; wr <= 0;
    @(posedge sys_clk);
  endtask : acc
  // Read monitor
  always @(posedge sys_clk)
    if (rd === 1'b1 && wt === 1'b0) cmp(q.pop_front(), rdat);
  // Random events and expected trigger count
  always @(posedge sys_clk)
  begin
    if (!sys_rst) cmp({31'h0, xp}, {31'h0, tg});
    xp = |(ev & tm);
    xh += {15'h0, xp};
    ev <= on ? 8'($random(seed)) : 8'h00;
  end
  task finish_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  initial
  begin
    #100000 fails++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    acc(0, 8'h30, 32'h0, 4'hf);
    for (i = 0; i < 10; i++)
    begin
      {ps, ws} <= 9'($random(seed));
      @(posedge sys_clk);
      acc(0, 8'h2c, {23'h0, ps, ws}, 4'hf);
      acc(1, 8'h2c, 32'hffffffff, 4'hf);
      acc(0, 8'h2c, {23'h0, ps, ws}, 4'hf);
      acc(1, 8'h30, i < 8 ? 32'hffffff00 | (32'h1 << i) : $random(seed),
          4'hf);
      acc(0, 8'h30, {24'h0, tm}, 4'hf);
      on <= 1;
      repeat (20) @(posedge sys_clk);
      on <= 0;
      acc(1, 8'h30, 32'h0, 4'he);
      acc(0, 8'h30, {24'h0, tm}, 4'hf);
      acc(0, 8'h44, 32'h0, 4'hf);
    end
    repeat (3) @(posedge sys_clk);
    cmp({16'h0, xh}, {16'h0, hits});
    finish_test();
  end
endmodule : profiler_saturation_event_combiner_tb

/* File: tb/psec_core_model.sv */
`timescale 1ns/1ps
module psec_core_model
(
  input  wire logic        sys_clk, // Clock
  input  wire logic        sys_rst, // Reset
  input  wire logic        trig,    // Combined event
  output logic      [15:0] hits     // Events seen
);
  // Trace logic counts combined events
  always_ff @(posedge sys_clk or posedge sys_rst)
    hits <= sys_rst ? 16'h0000 : hits + {15'h0000, trig};
endmodule : psec_core_model

/* File: tb/psec_top_sva.sv */
`timescale 1ns/1ps
module psec_top_sva
(
  input wire logic        sys_clk,                  // Clock
  input wire logic        sys_rst,                  // Reset
  input wire logic [7:0]  avs_address,              // Address
  input wire logic        avs_read,                 // Read
  input wire logic        avs_write,                // Write
  input wire logic [31:0] avs_writedata,            // Data in
  input wire logic [3:0]  avs_byteenable,           // Lanes
  input wire logic [31:0] avs_readdata,             // Data out
  input wire logic        avs_waitrequest,          // Stall
  input wire logic        prefetch_count_saturated, // Level
  input wire logic [7:0]  wait_count_saturated,     // Levels
  input wire logic [7:0]  wait_read_events,         // Events
  input wire logic        core_trace_trigger_event  // Trigger
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Mask mirror
  // ----------------------------------------
  logic [7:0] m;
  logic [7:0] next_m;
  wire        rd = avs_read && !avs_waitrequest;
  wire        wr = avs_write && !avs_waitrequest;
  always_comb
    next_m = (wr && avs_address == 8'h30 && avs_byteenable[0]) ?
             avs_writedata[7:0] : m;
  always_ff @(posedge sys_clk or posedge sys_rst)
    m <= sys_rst ? 8'h00 : next_m;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_comb; !$past(avs_write) |-> core_trace_trigger_event ==
    |($past(wait_read_events) & $past(m)); endproperty
  a_comb: assert property (p_comb) else $error("bad trigger");
  property p_cause; core_trace_trigger_event |->
    $past(wait_read_events) != 8'h00; endproperty
  a_cause: assert property (p_cause) else $error("no cause");
  property p_idle;
    wait_read_events == 8'h00 |=> !core_trace_trigger_event; endproperty
  a_idle: assert property (p_idle) else $error("idle trigger");
  property p_sat; ($stable({prefetch_count_saturated,
    wait_count_saturated}))[*2] ##0 (rd && avs_address == 8'h2c) |->
    avs_readdata == {23'h0, prefetch_count_saturated,
    wait_count_saturated}; endproperty
  a_sat: assert property (p_sat) else $error("bad status");
  property p_mask; rd && avs_address == 8'h30 |->
    avs_readdata == {24'h0, m}; endproperty
  a_mask: assert property (p_mask) else $error("bad mask");
  property p_unmap; rd && avs_address != 8'h2c && avs_address != 8'h30
    |-> avs_readdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_ack; $rose(avs_read || avs_write) |->
    ##[1:3] !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  c_trig: cover property (core_trace_trigger_event);
  c_stat: cover property (rd && avs_address == 8'h2c);
  c_mwr: cover property (wr && avs_address == 8'h30);
endmodule : psec_top_sva
bind psec_top psec_top_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .prefetch_count_saturated(prefetch_count_saturated),
  .wait_count_saturated(wait_count_saturated),
  .wait_read_events(wait_read_events),
  .core_trace_trigger_event(core_trace_trigger_event));
